// File: design/flash_status_defs.vh
// constants for the flash status and suspend-lock block
// Function
// RULE1 - lock, unlock and lock-down accepted while erase suspended; host polls bits 7,6
// RULE2 - host resumes the erase after lock changes during suspend
// RULE3 - lock setup followed by other command sets bits 4 and 5
// RULE4 - sequence error during suspend keeps bits 4,5 after resume
// RULE5 - lock bits of the suspended block change at once; erase completes
// RULE6 - no lock operations while a program is suspended
// RULE7 - password protection blocks access until a valid 64-bit password
// RULE8 - read status command at any address enters status mode
// RULE9 - status output after program, erase or lock sequence until new command
// RULE10 - status on low eight lanes, zero on upper eight lanes
// RULE11 - async status latched on first falling edge of oe or ce
// RULE12 - host toggles ce or address valid for fresh burst status
// RULE13 - page mode first word valid; burst repeats the same word
// RULE14 - bit 7 zero while busy, one when ready
// RULE15 - bit 6 set when erase suspended or suspend pending
// RULE16 - bits 5:4 encode outcome; any error aborts the operation
// RULE17 - bit 3 set when supply at or below lockout during operation
// RULE18 - bit 2 set when program suspended or suspend pending
// RULE19 - bit 1 set on program or erase of locked block; aborted
// RULE20 - bit 0 set while buffered factory-program data is loading
// RULE21 - reset value 0x80; bits 5:3 and 1 sticky until clear or reset
// RULE22 - host clears status or resets after error, 15 us delay
// RULE23 - lock codes 60h setup, 01h lock, D0h unlock, 2Fh lock-down
// RULE24 - host writes setup then lock-type command to target block
`ifndef FLASH_STATUS_DEFS_VH
`define FLASH_STATUS_DEFS_VH
`define CMD_LOCK_SETUP 8'h60
`define CMD_LOCK 8'h01
`define CMD_UNLOCK 8'hD0
`define CMD_LOCK_DOWN 8'h2F
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ARRAY 8'hFF
`define CMD_WORD_PROGRAM 8'h40
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'hD0
`define STATUS_RESET 8'h80
`define BIT_READY 7
`define BIT_ERASE_PAUSED 6
`define BIT_ERASE_FAIL 5
`define BIT_PROGRAM_FAIL 4
`define BIT_SUPPLY_LOW 3
`define BIT_PROGRAM_PAUSED 2
`define BIT_LOCKED_ABORT 1
`define BIT_BUFFER_LOAD 0
`define BLOCK_BITS 4
`define NUM_BLOCKS 16
`define PASSWORD_BITS 64
`define OP_TIME 16'h0010
`endif

// File: design/flash_status.v
// status register, command decoding and suspend-time lock logic
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module flash_status (
	// clock and reset
	input wire clk,
	input wire rstn,
	// flash bus pins
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire address_valid_n,
	input wire [3:0] blk_addr,
	input wire [15:0] dq_in,
	output reg [15:0] dq_out_ff,
	output reg dq_oe_ff,
	// device side inputs
	input wire burst_mode,
	input wire supply_low,
	input wire wp_n,
	input wire pw_protect,
	input wire [63:0] pw_value,
	input wire [63:0] pw_stored,
	input wire pw_strobe,
	input wire buffered_factory_program_loading,
	// device side outputs
	output reg [15:0] lock_ff,
	output reg [15:0] lockdown_ff,
	output reg array_access_ok_ff,
	output reg [7:0] status_out_ff
);
// ------------------------------------------------------------
// states
// ------------------------------------------------------------
localparam ST_IDLE = 6'b000001;
localparam ST_ERASE_SU = 6'b000010;
localparam ST_ERASE = 6'b000100;
localparam ST_PROG = 6'b001000;
localparam ST_LOCK_SU = 6'b010000;
localparam ST_E_PAUSED = 6'b100000;
reg [5:0] st_ff;
reg [5:0] ret_ff;
reg [7:0] sr_ff;
reg status_mode_ff;
reg prog_in_suspend_ff;
reg prog_paused_ff;
reg [3:0] erase_blk_ff;
reg [15:0] timer_ff;
reg unlocked_pw_ff;
// ------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------
reg [3:0] s1_ff;
reg [3:0] s2_ff;
reg [3:0] s3_ff;
reg [15:0] d1_ff;
reg [15:0] d2_ff;
reg [3:0] a1_ff;
reg [3:0] a2_ff;
// strobes idle high, so reset leaves no false edge behind
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		s1_ff <= 4'hF;
		s2_ff <= 4'hF;
		s3_ff <= 4'hF;
	end else begin
		s1_ff <= {address_valid_n, we_n, oe_n, ce_n};
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
	end
end

// command byte on the low lanes
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		d1_ff <= 16'h0000;
		d2_ff <= 16'h0000;
	end else begin
		d1_ff <= dq_in;
		d2_ff <= d1_ff;
	end
end

// target block index
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		a1_ff <= 4'h0;
		a2_ff <= 4'h0;
	end else begin
		a1_ff <= blk_addr;
		a2_ff <= a1_ff;
	end
end

// ------------------------------------------------------------
// strobe decoding
// ------------------------------------------------------------
wire ce_s = s2_ff[0];
wire oe_s = s2_ff[1];
// write taken when we_n returns high with the chip selected
wire we_rise = s2_ff[2] & ~s3_ff[2] & ~ce_s;
wire read_act = ~ce_s & ~oe_s;
// first of the two selects to fall opens the status latch
wire sel_fall = s3_ff[0] & s3_ff[1] & (~ce_s | ~oe_s);
// in burst a fresh select or address valid refreshes the word
wire read_start = read_act & (s3_ff[0] | s3_ff[1]);
wire adv_fall = ~s2_ff[3] & s3_ff[3];
wire [7:0] cmd = d2_ff[7:0];
wire [3:0] blk = a2_ff;

function is_lock_type;
	input [7:0] c;
	begin
		is_lock_type = (c == `CMD_LOCK) || (c == `CMD_UNLOCK) ||
			(c == `CMD_LOCK_DOWN); // RULE23
	end
endfunction

// true while a program or erase runs
function is_busy;
	input [5:0] s;
	begin
		is_busy = (s == ST_ERASE) || (s == ST_PROG);
	end
endfunction

// ------------------------------------------------------------
// command state machine
// ------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		st_ff <= ST_IDLE;
		ret_ff <= ST_IDLE;
		sr_ff <= `STATUS_RESET; // RULE21
		status_mode_ff <= 1'b0;
		prog_in_suspend_ff <= 1'b0;
		prog_paused_ff <= 1'b0;
		erase_blk_ff <= 4'h0;
		timer_ff <= 16'h0000;
		lock_ff <= 16'hFFFF;
		lockdown_ff <= 16'h0000;
	end else begin
		sr_ff[`BIT_BUFFER_LOAD] <= buffered_factory_program_loading; // RULE20
		sr_ff[`BIT_PROGRAM_PAUSED] <= prog_paused_ff; // RULE18
		// a supply drop aborts the running operation
		if (is_busy(st_ff) && supply_low) begin
			sr_ff[`BIT_SUPPLY_LOW] <= 1'b1; // RULE17
			sr_ff[`BIT_READY] <= 1'b1; // RULE16
			st_ff <= ST_IDLE;
		end else if (is_busy(st_ff) && timer_ff != 16'h0000) begin
			timer_ff <= timer_ff - 16'h0001;
		end else if (is_busy(st_ff)) begin
			// a program run inside an erase pause returns there
			sr_ff[`BIT_READY] <= 1'b1; // RULE14
			st_ff <= prog_in_suspend_ff ? ST_E_PAUSED : ST_IDLE;
			prog_in_suspend_ff <= 1'b0;
		end
		if (we_rise) begin
			case (st_ff)
			ST_LOCK_SU: begin
				st_ff <= ret_ff;
				status_mode_ff <= 1'b1; // RULE9
				if (!is_lock_type(cmd)) begin
					sr_ff[5:4] <= 2'b11; // RULE3
				end else if (prog_paused_ff) begin
					sr_ff[5:4] <= 2'b11; // RULE6
				end else if (cmd == `CMD_LOCK) begin
					lock_ff[blk] <= 1'b1; // RULE5
				end else if (cmd == `CMD_LOCK_DOWN) begin
					lock_ff[blk] <= 1'b1;
					lockdown_ff[blk] <= 1'b1; // RULE5
				end else if (!lockdown_ff[blk] || wp_n) begin
					lock_ff[blk] <= 1'b0;
					lockdown_ff[blk] <= 1'b0;
				end
			end
			ST_ERASE_SU: begin
				status_mode_ff <= 1'b1;
				if (cmd == `CMD_CONFIRM && lock_ff[blk]) begin
					sr_ff[`BIT_LOCKED_ABORT] <= 1'b1; // RULE19
					sr_ff[`BIT_ERASE_FAIL] <= 1'b1;
					st_ff <= ST_IDLE;
				end else if (cmd == `CMD_CONFIRM) begin
					sr_ff[`BIT_READY] <= 1'b0;
					erase_blk_ff <= blk;
					timer_ff <= `OP_TIME;
					st_ff <= ST_ERASE;
				end else begin
					sr_ff[5:4] <= 2'b11;
					st_ff <= ST_IDLE;
				end
			end
			ST_PROG: begin
				if (cmd == `CMD_SUSPEND) begin
					prog_paused_ff <= 1'b1; // RULE18
					// a paused program leaves the device ready
					sr_ff[`BIT_READY] <= 1'b1; // RULE14
					st_ff <= ST_IDLE;
				end
			end
			ST_ERASE: begin
				if (cmd == `CMD_SUSPEND) begin
					sr_ff[`BIT_ERASE_PAUSED] <= 1'b1; // RULE15
					sr_ff[`BIT_READY] <= 1'b1; // RULE1
					st_ff <= ST_E_PAUSED;
				end
			end
			default: begin
				status_mode_ff <= 1'b0;
				case (cmd)
				`CMD_READ_STATUS: status_mode_ff <= 1'b1; // RULE8
				`CMD_CLEAR_STATUS: begin
					sr_ff[5:3] <= 3'b000; // RULE21
					sr_ff[`BIT_LOCKED_ABORT] <= 1'b0;
					status_mode_ff <= status_mode_ff;
				end
				`CMD_LOCK_SETUP: begin
					ret_ff <= st_ff; // RULE1
					st_ff <= ST_LOCK_SU;
					status_mode_ff <= status_mode_ff;
				end
				`CMD_ERASE_SETUP: begin
					if (st_ff == ST_IDLE)
						st_ff <= ST_ERASE_SU;
				end
				`CMD_RESUME: begin
					status_mode_ff <= 1'b1;
					if (prog_paused_ff) begin
						prog_paused_ff <= 1'b0;
						sr_ff[`BIT_READY] <= 1'b0;
						st_ff <= ST_PROG;
					end else if (st_ff == ST_E_PAUSED) begin
						sr_ff[`BIT_ERASE_PAUSED] <= 1'b0; // RULE4
						sr_ff[`BIT_READY] <= 1'b0; // RULE5
						st_ff <= ST_ERASE;
					end
				end
				`CMD_WORD_PROGRAM: begin
					status_mode_ff <= 1'b1;
					st_ff <= ST_PROG;
					if (st_ff == ST_E_PAUSED &&
						blk == erase_blk_ff) begin
						sr_ff[5:4] <= 2'b11;
						st_ff <= ST_E_PAUSED;
					end else if (lock_ff[blk]) begin
						sr_ff[`BIT_LOCKED_ABORT] <= 1'b1; // RULE19
						sr_ff[`BIT_PROGRAM_FAIL] <= 1'b1;
						st_ff <= st_ff;
					end else begin
						prog_in_suspend_ff <= (st_ff == ST_E_PAUSED);
						sr_ff[`BIT_READY] <= 1'b0;
						timer_ff <= `OP_TIME;
					end
				end
				default: status_mode_ff <= 1'b0;
				endcase
			end
			endcase
		end
	end
end

// ------------------------------------------------------------
// password gate
// ------------------------------------------------------------
// the gate stays open until the next reset
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		unlocked_pw_ff <= 1'b0;
		array_access_ok_ff <= 1'b0;
	end else begin
		if (pw_strobe && pw_value == pw_stored)
			unlocked_pw_ff <= 1'b1; // RULE7
		array_access_ok_ff <= ~pw_protect | unlocked_pw_ff; // RULE7
	end
end

// ------------------------------------------------------------
// status latch
// ------------------------------------------------------------
// the word changes only on a select or, in burst, on an address valid fall, so a poll sees one value
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		status_out_ff <= `STATUS_RESET;
	end else begin
		if (!burst_mode && sel_fall)
			status_out_ff <= sr_ff; // RULE11
		else if (burst_mode && (read_start || adv_fall))
			status_out_ff <= sr_ff; // RULE12
	end
end

// ------------------------------------------------------------
// read data path
// ------------------------------------------------------------
// the same word repeats for every beat of a burst
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		dq_out_ff <= 16'h0000;
		dq_oe_ff <= 1'b0;
	end else begin
		dq_oe_ff <= read_act;
		if (status_mode_ff)
			dq_out_ff <= {8'h00, status_out_ff}; // RULE10 RULE13
		else
			dq_out_ff <= 16'h0000;
	end
end
endmodule

// File: sim/flash_host.sv
// host bus model that writes commands and reads status
`timescale 1ns/1ps
module flash_host (
	// clock
	input wire clk,
	// flash pins
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic address_valid_n,
	output logic [3:0] blk_addr,
	output logic [15:0] dq_in,
	input wire [15:0] dq_out_ff
);
	initial {ce_n, oe_n, we_n, address_valid_n} = 4'hf;
	initial {blk_addr, dq_in} = 20'h0_0000;
	// released data lines show the inverse of the last value
	task wr(input logic [7:0] c, input logic [3:0] b);
		@(posedge clk);
		ce_n <= 1'h0;
		we_n <= 1'h0;
		blk_addr <= b;
		dq_in <= {8'h00, c};
		repeat (2) @(posedge clk);
		we_n <= 1'h1;
		repeat (2) @(posedge clk);
		ce_n <= 1'h1;
		dq_in <= {8'hff, ~c};
		repeat (4) @(posedge clk);
	endtask
	task rd(output logic [15:0] d);
		@(posedge clk);
		ce_n <= 1'h0;
		oe_n <= 1'h0;
		repeat (6) @(posedge clk);
		d = dq_out_ff;
		ce_n <= 1'h1;
		oe_n <= 1'h1;
		repeat (4) @(posedge clk);
	endtask
	task lk(input logic [7:0] c, input logic [3:0] b);
		wr(8'h60, b);
		wr(c, b);
	endtask
	// 15 us settling before the clear command
	task clr;
		repeat (300) @(posedge clk);
		wr(8'h50, 4'h0);
	endtask
endmodule

// File: sim/flash_status_chk.sv
// port assertions for the flash status block
`timescale 1ns/1ps
module flash_status_chk (
	// clock and reset
	input wire clk,
	input wire rstn,
	// bus pins
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire [15:0] dq_in,
	input wire [15:0] dq_out_ff,
	input wire dq_oe_ff,
	// device side
	input wire pw_protect,
	input wire [63:0] pw_value,
	input wire [63:0] pw_stored,
	input wire pw_strobe,
	input wire [15:0] lock_ff,
	input wire [15:0] lockdown_ff,
	input wire array_access_ok_ff,
	input wire [7:0] status_out_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic clr_seen_ff;
	logic [3:0] since_we_ff;
	wire [3:0] sticky = {status_out_ff[5:3], status_out_ff[1]};
	wire good_pw = pw_strobe && pw_value == pw_stored;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clr_seen_ff <= 1'h0;
			since_we_ff <= 4'hf;
		end else begin
			if (!ce_n && !we_n && dq_in[7:0] == 8'h50)
				clr_seen_ff <= 1'h1;
			else if (sticky == 4'h0)
				clr_seen_ff <= 1'h0;
			if (!we_n)
				since_we_ff <= 4'h0;
			else if (since_we_ff != 4'hf)
				since_we_ff <= since_we_ff + 4'h1;
		end
	end
	sequence read_held;
		(!ce_n && !oe_n) [*6];
	endsequence
	reset_value_a: assert property ($rose(rstn) |-> status_out_ff == 8'h80)
		else $error("reset status wrong");
	upper_zero_a: assert property (dq_oe_ff |-> dq_out_ff[15:8] == 8'h00)
		else $error("upper lanes not zero");
	drive_on_a: assert property (read_held |-> dq_oe_ff)
		else $error("no drive in read");
	drive_off_a: assert property (ce_n [*6] |-> !dq_oe_ff)
		else $error("drive while deselected");
	sticky_hold_a: assert property ((|($past(sticky) & ~sticky)) |-> clr_seen_ff)
		else $error("sticky bit dropped");
	lock_cause_a: assert property (($changed(lock_ff) || $changed(lockdown_ff))
		|-> since_we_ff < 4'hc)
		else $error("lock change without write");
	access_open_a: assert property (!pw_protect [*4] |-> array_access_ok_ff)
		else $error("access shut unprotected");
	access_shut_a: assert property (pw_protect && !array_access_ok_ff &&
		!good_pw && !$past(good_pw) ##1 pw_protect |-> !array_access_ok_ff)
		else $error("access opened without password");
endmodule
bind flash_status flash_status_chk u_flash_status_chk (.*);

// File: sim/tb.sv
// self-checking bench for the flash status block
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module tb;
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic ce_n, oe_n, we_n, address_valid_n, dq_oe_ff, array_access_ok_ff;
	logic [3:0] blk_addr;
	logic [15:0] dq_in, dq_out_ff, lock_ff, lockdown_ff, d;
	logic [7:0] status_out_ff;
	logic burst_mode = 1'h0, supply_low = 1'h0, wp_n = 1'h1;
	logic pw_protect = 1'h0, pw_strobe = 1'h0, buffered_factory_program_loading = 1'h0;
	logic [63:0] pw_value = 64'h0;
	logic [63:0] pw_stored = 64'h1234_5678_9abc_def0;
	int n_mismatch = 0, checks_done = 0;
	always #25 clk = ~clk;
	flash_status u_flash_status (.*);
	flash_host u_flash_host (.*);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task st(input logic [7:0] e);
		u_flash_host.rd(d);
		chk(d, {8'h00, e});
	endtask
	task pw(input logic [63:0] v);
		pw_value <= v;
		pw_strobe <= 1'h1;
		@(posedge clk);
		pw_strobe <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task close_out;
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out;
	end
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		u_flash_host.wr(`CMD_READ_STATUS, 4'h3);
		st(8'h80);
		u_flash_host.lk(`CMD_READ_ARRAY, 4'h0);
		st(8'hb0);
		u_flash_host.clr;
		st(8'h80);
		u_flash_host.lk(`CMD_UNLOCK, 4'h4);
		u_flash_host.lk(`CMD_LOCK_DOWN, 4'h5);
		chk({lock_ff[4], lockdown_ff[5]}, 16'h0001);
		buffered_factory_program_loading <= 1'h1;
		st(8'h81);
		buffered_factory_program_loading <= 1'h0;
		burst_mode <= 1'h1;
		st(8'h80);
		burst_mode <= 1'h0;
		u_flash_host.wr(`CMD_ERASE_SETUP, 4'h4);
		u_flash_host.wr(`CMD_CONFIRM, 4'h4);
		st(8'h00);
		repeat (20) @(posedge clk);
		st(8'h80);
		u_flash_host.wr(`CMD_ERASE_SETUP, 4'h4);
		u_flash_host.wr(`CMD_CONFIRM, 4'h4);
		u_flash_host.wr(`CMD_SUSPEND, 4'h4);
		repeat (30) @(posedge clk);
		st(8'hc0);
		u_flash_host.lk(`CMD_LOCK, 4'h4);
		chk({15'h0, lock_ff[4]}, 16'h0001);
		u_flash_host.lk(`CMD_READ_ARRAY, 4'h4);
		st(8'hf0);
		u_flash_host.wr(`CMD_RESUME, 4'h4);
		repeat (30) @(posedge clk);
		st(8'hb0);
		u_flash_host.clr;
		u_flash_host.wr(`CMD_ERASE_SETUP, 4'h7);
		u_flash_host.wr(`CMD_CONFIRM, 4'h7);
		repeat (30) @(posedge clk);
		st(8'ha2);
		u_flash_host.clr;
		u_flash_host.lk(`CMD_UNLOCK, 4'h9);
		u_flash_host.wr(`CMD_WORD_PROGRAM, 4'h9);
		u_flash_host.wr(`CMD_SUSPEND, 4'h9);
		repeat (30) @(posedge clk);
		st(8'h84);
		u_flash_host.lk(`CMD_LOCK, 4'h9);
		chk({15'h0, lock_ff[9]}, 16'h0000);
		st(8'hb4);
		u_flash_host.clr;
		supply_low <= 1'h1;
		u_flash_host.wr(`CMD_ERASE_SETUP, 4'h9);
		u_flash_host.wr(`CMD_CONFIRM, 4'h9);
		repeat (30) @(posedge clk);
		u_flash_host.rd(d);
		chk({15'h0, d[3]}, 16'h0001);
		supply_low <= 1'h0;
		pw_protect <= 1'h1;
		pw(64'h0);
		chk({15'h0, array_access_ok_ff}, 16'h0000);
		pw(pw_stored);
		chk({15'h0, array_access_ok_ff}, 16'h0001);
		close_out;
	end
endmodule
